//--- ord_pkg.sv
package ord_pkg;

  // Memory bus geometry
  localparam int ADDR_W = 24;
  localparam int DATA_W = 8;
  localparam int PAGE_LSB = 16;
  localparam int NUM_CS = 4;

  // Region bounds inside the selected 64 KB page
  localparam logic [15:0] GP_LO = 16'hE000;
  localparam logic [15:0] GP_HI = 16'hFFFF;
  localparam logic [15:0] MAC_LO = 16'hDC00;
  localparam logic [15:0] MAC_HI = 16'hDFFF;

  // RAM sizes in bytes
  localparam int GP_DEPTH = 8192;
  localparam int MAC_DEPTH = 1024;

  // Register indices; byte address on the bus is four times the index
  localparam int AV_ADDR_W = 10;
  localparam logic [7:0] PAGE_IDX = 8'hB5;
  localparam logic [7:0] CTRL_IDX = 8'hB6;
  localparam logic [AV_ADDR_W-1:0] PAGE_BADDR = {PAGE_IDX, 2'h0};
  localparam logic [AV_ADDR_W-1:0] CTRL_BADDR = {CTRL_IDX, 2'h0};

  // Control register layout and reset values
  localparam int CTRL_GP_BIT = 7;
  localparam int CTRL_MAC_BIT = 6;
  localparam logic [7:0] PAGE_RESET = 8'h00;
  localparam logic CTRL_EN_RESET = 1'h0;
  localparam logic [5:0] CTRL_RSVD_VALUE = 6'h00;

  // Register bus handshake states
  typedef enum logic [1:0] {
    ORD_BUS_IDLE = 2'h1,
    ORD_BUS_ACK = 2'h2
  } ord_bus_state_type;

  // One processor memory bus cycle
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic rd;
    logic wr;
    logic [DATA_W-1:0] wdata;
  } ord_mem_req_type;

  // Bounds and enable of one memory chip select
  typedef struct packed {
    logic [7:0] lower;
    logic [7:0] upper;
    logic enable;
  } ord_cs_range_type;

  // Whole state of the decoder
  typedef struct packed {
    ord_bus_state_type bus_state;
    logic waitreq;
    logic [31:0] readdata;
    logic [7:0] page;
    logic gp_en;
    logic mac_en;
    logic [DATA_W-1:0] mem_rdata;
    logic mem_rvalid;
    logic gp_hit;
    logic mac_hit;
    logic [NUM_CS-1:0] cs_n;
  } ord_state_type;

endpackage

//--- ord_ram.sv
`timescale 1ns/1ns
module ord_ram #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 1024,
  parameter int AW = $clog2(DEPTH)
) (
  input wire logic clk,
  input wire logic we,
  input wire logic [AW-1:0] addr,
  input wire logic [WIDTH-1:0] wdata,
  output logic [WIDTH-1:0] rdata
);

  logic [WIDTH-1:0] mem [DEPTH];

  // Write at the clock edge of the bus cycle
  always_ff @(posedge clk) begin
    if (we) begin
      mem[addr] <= wdata;
    end
  end

  // Read is combinational; the caller registers the result
  assign rdata = mem[addr];

endmodule

//--- ord_top.sv
`timescale 1ns/1ns
// How it works
// - Holds an 8 KB by 8 data RAM and a 1 KB by 8 shared RAM.
// - Both RAMs read and write over the one 8-bit processor data bus.
// - Both RAMs sit at the top of a 64 KB page that software moves.
// - Data RAM, when enabled, answers page addresses E000h through FFFFh.
// - Shared RAM, when enabled, answers page addresses DC00h through DFFFh.
// - An 8-bit read/write page register gives address bits 23 to 16.
// - Control bit 7 switches the data RAM on or off.
// - Control bit 6 switches the shared RAM; bits 5 to 0 read zero only.
// - An enabled RAM hit keeps any overlapping memory chip select inactive.
// - Decoding looks at the whole 24-bit address, 16 MB space.
// - A memory chip select compares address bits 23 to 16 with its bounds.
module ord_top #(
  parameter int GP_DEPTH = ord_pkg::GP_DEPTH,
  parameter int MAC_DEPTH = ord_pkg::MAC_DEPTH
) (
  input wire logic MCLK,
  input wire logic RST,
  input wire logic [ord_pkg::AV_ADDR_W-1:0] AV_ADDRESS,
  input wire logic AV_READ,
  input wire logic AV_WRITE,
  input wire logic [31:0] AV_WRITEDATA,
  input wire logic [3:0] AV_BYTEENABLE,
  output logic [31:0] AV_READDATA,
  output logic AV_WAITREQUEST,
  input ord_pkg::ord_mem_req_type MEM_REQ,
  input ord_pkg::ord_cs_range_type [ord_pkg::NUM_CS-1:0] CS_RANGE,
  output logic [ord_pkg::DATA_W-1:0] MEM_RDATA,
  output logic MEM_RVALID,
  output logic MEM_GP_HIT,
  output logic MEM_MAC_HIT,
  output logic [ord_pkg::NUM_CS-1:0] MEM_CS_N
);

  localparam int GP_AW = $clog2(GP_DEPTH);
  localparam int MAC_AW = $clog2(MAC_DEPTH);

  ord_pkg::ord_state_type state_reg;
  ord_pkg::ord_state_type state_next;

  logic [7:0] addr_upper;
  logic [15:0] addr_lower;
  logic mem_access;
  logic page_match;
  logic gp_sel;
  logic mac_sel;
  logic ram_sel;
  logic [ord_pkg::NUM_CS-1:0] cs_in_range;
  logic [ord_pkg::DATA_W-1:0] gp_rdata;
  logic [ord_pkg::DATA_W-1:0] mac_rdata;
  logic av_page_sel;
  logic av_ctrl_sel;
  logic [31:0] av_read_mux;

  // Split the 24-bit address into page byte and in-page offset
  assign addr_upper = MEM_REQ.addr[ord_pkg::ADDR_W-1:ord_pkg::PAGE_LSB];
  assign addr_lower = MEM_REQ.addr[ord_pkg::PAGE_LSB-1:0];
  assign mem_access = MEM_REQ.rd | MEM_REQ.wr;

  // Region decode; the page byte relocates both RAMs together
  assign page_match = (addr_upper == state_reg.page);
  assign gp_sel = state_reg.gp_en & page_match & mem_access &
    (addr_lower >= ord_pkg::GP_LO) & (addr_lower <= ord_pkg::GP_HI);
  assign mac_sel = state_reg.mac_en & page_match & mem_access &
    (addr_lower >= ord_pkg::MAC_LO) & (addr_lower <= ord_pkg::MAC_HI);
  assign ram_sel = gp_sel | mac_sel;

  // Chip select bound compare, one comparator per select
  for (genvar i = 0; i < ord_pkg::NUM_CS; i++) begin : g_cs
    assign cs_in_range[i] = CS_RANGE[i].enable &
      (addr_upper >= CS_RANGE[i].lower) & (addr_upper <= CS_RANGE[i].upper);
  end

  // General-purpose data RAM
  ord_ram #(
    .WIDTH(ord_pkg::DATA_W),
    .DEPTH(GP_DEPTH),
    .AW(GP_AW)
  ) u_gp_ram (
    .clk(MCLK),
    .we(gp_sel & MEM_REQ.wr),
    .addr(addr_lower[GP_AW-1:0]),
    .wdata(MEM_REQ.wdata),
    .rdata(gp_rdata)
  );

  // Shared RAM; only the processor port lives in this block
  ord_ram #(
    .WIDTH(ord_pkg::DATA_W),
    .DEPTH(MAC_DEPTH),
    .AW(MAC_AW)
  ) u_mac_ram (
    .clk(MCLK),
    .we(mac_sel & MEM_REQ.wr),
    .addr(addr_lower[MAC_AW-1:0]),
    .wdata(MEM_REQ.wdata),
    .rdata(mac_rdata)
  );

  // Register address decode and read data
  assign av_page_sel = (AV_ADDRESS == ord_pkg::PAGE_BADDR);
  assign av_ctrl_sel = (AV_ADDRESS == ord_pkg::CTRL_BADDR);

  always_comb begin
    av_read_mux = 32'h0000_0000;
    if (av_page_sel) begin
      av_read_mux[7:0] = state_reg.page;
    end else if (av_ctrl_sel) begin
      av_read_mux[ord_pkg::CTRL_GP_BIT] = state_reg.gp_en;
      av_read_mux[ord_pkg::CTRL_MAC_BIT] = state_reg.mac_en;
      av_read_mux[5:0] = ord_pkg::CTRL_RSVD_VALUE;
    end
  end

  // Next state: register bus handshake, register writes, memory side outputs
  always_comb begin
    state_next = state_reg;
    // Memory side: one-cycle read return, hit flags follow the access
    state_next.mem_rvalid = ram_sel & MEM_REQ.rd;
    state_next.gp_hit = gp_sel;
    state_next.mac_hit = mac_sel;
    if (gp_sel & MEM_REQ.rd) begin
      state_next.mem_rdata = gp_rdata;
    end else if (mac_sel & MEM_REQ.rd) begin
      state_next.mem_rdata = mac_rdata;
    end
    // Internal RAM wins; an overlapping select stays high
    for (int k = 0; k < ord_pkg::NUM_CS; k++) begin
      state_next.cs_n[k] = ~(cs_in_range[k] & mem_access & ~ram_sel);
    end
    // Waitrequest stays high while idle, drops for exactly one cycle
    case (state_reg.bus_state)
      ord_pkg::ORD_BUS_IDLE: begin
        if (AV_READ | AV_WRITE) begin
          state_next.bus_state = ord_pkg::ORD_BUS_ACK;
          state_next.waitreq = 1'h0;
          state_next.readdata = AV_READ ? av_read_mux : 32'h0000_0000;
        end
      end
      ord_pkg::ORD_BUS_ACK: begin
        // Write lands at the edge where the master sees waitrequest low
        if (AV_WRITE & AV_BYTEENABLE[0]) begin
          if (av_page_sel) begin
            state_next.page = AV_WRITEDATA[7:0];
          end else if (av_ctrl_sel) begin
            state_next.gp_en = AV_WRITEDATA[ord_pkg::CTRL_GP_BIT];
            state_next.mac_en = AV_WRITEDATA[ord_pkg::CTRL_MAC_BIT];
          end
        end
        state_next.bus_state = ord_pkg::ORD_BUS_IDLE;
        state_next.waitreq = 1'h1;
      end
      default: begin
        state_next.bus_state = ord_pkg::ORD_BUS_IDLE;
        state_next.waitreq = 1'h1;
      end
    endcase
  end

  // State register with synchronous reset
  always_ff @(posedge MCLK) begin
    if (RST) begin
      state_reg.bus_state <= ord_pkg::ORD_BUS_IDLE;
      state_reg.waitreq <= 1'h1;
      state_reg.readdata <= 32'h0000_0000;
      state_reg.page <= ord_pkg::PAGE_RESET;
      state_reg.gp_en <= ord_pkg::CTRL_EN_RESET;
      state_reg.mac_en <= ord_pkg::CTRL_EN_RESET;
      state_reg.mem_rdata <= 8'h00;
      state_reg.mem_rvalid <= 1'h0;
      state_reg.gp_hit <= 1'h0;
      state_reg.mac_hit <= 1'h0;
      state_reg.cs_n <= '1;
    end else begin
      state_reg <= state_next;
    end
  end

  // Outputs straight from the state register
  assign AV_READDATA = state_reg.readdata;
  assign AV_WAITREQUEST = state_reg.waitreq;
  assign MEM_RDATA = state_reg.mem_rdata;
  assign MEM_RVALID = state_reg.mem_rvalid;
  assign MEM_GP_HIT = state_reg.gp_hit;
  assign MEM_MAC_HIT = state_reg.mac_hit;
  assign MEM_CS_N = state_reg.cs_n;

  // Checks on the decoder
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (RST);

  sequence gp_region_s;
    state_reg.gp_en && mem_access && (addr_upper == state_reg.page) &&
      (addr_lower >= ord_pkg::GP_LO) && (addr_lower <= ord_pkg::GP_HI);
  endsequence

  sequence mac_region_s;
    state_reg.mac_en && mem_access && (addr_upper == state_reg.page) &&
      (addr_lower >= ord_pkg::MAC_LO) && (addr_lower <= ord_pkg::MAC_HI);
  endsequence

  sequence bus_ack_s;
    !AV_WAITREQUEST ##1 AV_WAITREQUEST;
  endsequence

  gp_decode_a: assert property (gp_region_s |=> MEM_GP_HIT && !MEM_MAC_HIT)
    else $error("data RAM region not claimed");

  mac_decode_a: assert property (mac_region_s |=> MEM_MAC_HIT && !MEM_GP_HIT)
    else $error("shared RAM region not claimed");

  cs_suppress_a: assert property ((gp_region_s or mac_region_s) |=> (&MEM_CS_N))
    else $error("chip select active on internal RAM hit");

  ram_off_a: assert property ((!state_reg.gp_en && !state_reg.mac_en) |=>
    !MEM_GP_HIT && !MEM_MAC_HIT && !MEM_RVALID)
    else $error("disabled RAM claimed an access");

  bus_handshake_a: assert property ((AV_READ || AV_WRITE) && AV_WAITREQUEST &&
    (state_reg.bus_state == ord_pkg::ORD_BUS_IDLE) |=> bus_ack_s)
    else $error("register bus answer not one cycle");

  page_store_a: assert property (AV_WRITE && !AV_WAITREQUEST && AV_BYTEENABLE[0] &&
    av_page_sel |=> state_reg.page == $past(AV_WRITEDATA[7:0]))
    else $error("page register not written");

  ctrl_store_a: assert property (AV_WRITE && !AV_WAITREQUEST && AV_BYTEENABLE[0] &&
    av_ctrl_sel |=> state_reg.gp_en == $past(AV_WRITEDATA[7]) &&
    state_reg.mac_en == $past(AV_WRITEDATA[6]))
    else $error("control enables not written");

  ctrl_reserved_a: assert property (!AV_WAITREQUEST && AV_READ && av_ctrl_sel |->
    AV_READDATA[5:0] == 6'h00 && AV_READDATA[31:8] == 24'h000000)
    else $error("reserved control bits not zero");

  hit_page_a: assert property ((MEM_GP_HIT || MEM_MAC_HIT) |->
    $past(addr_upper) == $past(state_reg.page))
    else $error("hit outside the selected page");

  // Per select: low only inside its enabled bounds, and low there unless a RAM claims it
  for (genvar j = 0; j < ord_pkg::NUM_CS; j++) begin : g_cs_chk
    cs_bound_a: assert property (@(posedge MCLK) disable iff (RST) !MEM_CS_N[j] |->
      $past(CS_RANGE[j].enable) && ($past(addr_upper) >= $past(CS_RANGE[j].lower)) &&
      ($past(addr_upper) <= $past(CS_RANGE[j].upper)) && !MEM_GP_HIT && !MEM_MAC_HIT)
      else $error("chip select outside its bounds");

    cs_drive_a: assert property (@(posedge MCLK) disable iff (RST)
      CS_RANGE[j].enable && mem_access && (addr_upper >= CS_RANGE[j].lower) &&
      (addr_upper <= CS_RANGE[j].upper) |=> !MEM_CS_N[j] || MEM_GP_HIT || MEM_MAC_HIT)
      else $error("chip select missing inside its bounds");
  end

  read_return_a: assert property (MEM_RVALID |-> $past(MEM_REQ.rd) &&
    (MEM_RDATA == ($past(gp_sel) ? $past(gp_rdata) : $past(mac_rdata))))
    else $error("read data not from the hit RAM");

  ram_write_a: assert property ((gp_region_s or mac_region_s) ##0 MEM_REQ.wr |=>
    !MEM_RVALID)
    else $error("write returned read data");

  // Register bus steps that the checks below are built from
  sequence reg_read_s;
    AV_READ && !AV_WAITREQUEST;
  endsequence

  sequence reg_write_s;
    AV_WRITE && !AV_WAITREQUEST && AV_BYTEENABLE[0];
  endsequence

  // A memory cycle aimed at some other page than the relocated one
  sequence page_miss_s;
    mem_access && (addr_upper != state_reg.page);
  endsequence

  // The two regions never overlap, so one cycle claims one RAM at most
  hit_onehot_a: assert property (!(MEM_GP_HIT && MEM_MAC_HIT))
    else $error("both RAMs claimed one access");

  // Another page never reaches either RAM, whatever its offset
  page_miss_a: assert property (page_miss_s |=> !MEM_GP_HIT && !MEM_MAC_HIT && !MEM_RVALID)
    else $error("access outside the page hit a RAM");

  // Offsets below the shared region belong to ordinary memory
  low_offset_a: assert property (mem_access && (addr_lower < ord_pkg::MAC_LO) |=>
    !MEM_GP_HIT && !MEM_MAC_HIT)
    else $error("offset below the RAM regions hit a RAM");

  // Each enable gates its own RAM only
  gp_off_a: assert property (!state_reg.gp_en |=> !MEM_GP_HIT)
    else $error("disabled data RAM claimed an access");

  mac_off_a: assert property (!state_reg.mac_en |=> !MEM_MAC_HIT)
    else $error("disabled shared RAM claimed an access");

  // A hit flag always points back to an enabled RAM and a real bus cycle
  hit_cause_a: assert property (MEM_GP_HIT || MEM_MAC_HIT |-> $past(mem_access) &&
    (MEM_GP_HIT ? $past(state_reg.gp_en) : $past(state_reg.mac_en)))
    else $error("hit without an enabled RAM");

  // No bus cycle means no select, no hit and no read return
  idle_quiet_a: assert property (!mem_access |=> (&MEM_CS_N) && !MEM_RVALID &&
    !MEM_GP_HIT && !MEM_MAC_HIT)
    else $error("outputs active without a memory cycle");

  // Read data only moves when a RAM read returns
  rdata_hold_a: assert property (!MEM_RVALID |-> $stable(MEM_RDATA))
    else $error("memory read data moved without a read");

  // Read data in the answer cycle is the live register content
  page_read_a: assert property (reg_read_s ##0 av_page_sel |->
    AV_READDATA == {24'h000000, state_reg.page})
    else $error("page register read back wrong");

  ctrl_read_a: assert property (reg_read_s ##0 av_ctrl_sel |->
    (AV_READDATA[ord_pkg::CTRL_GP_BIT] == state_reg.gp_en) &&
    (AV_READDATA[ord_pkg::CTRL_MAC_BIT] == state_reg.mac_en))
    else $error("control register read back wrong");

  // Unmapped offsets read as zero
  unmapped_read_a: assert property (reg_read_s ##0 (!av_page_sel && !av_ctrl_sel) |->
    AV_READDATA == 32'h0000_0000)
    else $error("unmapped register read not zero");

  // Registers change only through an accepted write with the low byte enabled
  page_hold_a: assert property (
    !(AV_WRITE && !AV_WAITREQUEST && AV_BYTEENABLE[0] && av_page_sel) |=> $stable(state_reg.page))
    else $error("page register changed without a write");

  ctrl_hold_a: assert property (
    !(AV_WRITE && !AV_WAITREQUEST && AV_BYTEENABLE[0] && av_ctrl_sel) |=>
    $stable(state_reg.gp_en) && $stable(state_reg.mac_en))
    else $error("control enables changed without a write");

  // A write answer carries no read data
  write_answer_a: assert property (reg_write_s |-> AV_READDATA == 32'h0000_0000)
    else $error("write answer carried read data");

  // Registers are 8 bits wide; the rest of the word always reads zero
  readdata_upper_a: assert property (AV_READDATA[31:8] == 24'h000000)
    else $error("upper read data bits not zero");

  // With no request the slave stays busy and its last answer stands
  bus_idle_a: assert property (AV_WAITREQUEST && !AV_READ && !AV_WRITE |=>
    AV_WAITREQUEST && $stable(AV_READDATA))
    else $error("register bus moved without a request");

endmodule

//--- ord_cpu_model.sv
`timescale 1ns/1ns
// Processor side of the memory bus: one access per command cycle
module ord_cpu_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic cmd_valid,
  input ord_pkg::ord_mem_req_type cmd,
  output ord_pkg::ord_mem_req_type mem_req
);
  // Idle lines wander every cycle so a stale address never looks valid
  always_ff @(posedge clk) begin
    if (rst) begin
      mem_req <= '{addr: 24'h5A5A5A, rd: 1'b0, wr: 1'b0, wdata: 8'hA5};
    end else if (cmd_valid) begin
      mem_req <= cmd;
    end else begin
      mem_req <= '{addr: ~mem_req.addr, rd: 1'b0, wr: 1'b0, wdata: ~mem_req.wdata};
    end
  end
endmodule

//--- ord_top_tb.sv
`timescale 1ns/1ns
// Drives registers and memory cycles and keeps a reference of the decode
module ord_top_tb;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic [9:0] av_addr = 10'h000;
  logic av_rd = 1'b0;
  logic av_wr = 1'b0;
  logic [31:0] av_wdata = 32'h00000000;
  logic [3:0] av_be = 4'h0;
  logic [31:0] av_rdata;
  logic av_wait;
  ord_pkg::ord_mem_req_type cmd = '0;
  ord_pkg::ord_mem_req_type mem_req;
  logic cmd_v = 1'b0;
  ord_pkg::ord_cs_range_type [3:0] cs = '0;
  logic [7:0] mem_rdata;
  logic mem_rvalid, gp_hit, mac_hit;
  logic [3:0] cs_n;
  int n_mismatch = 0;
  int num_checks = 0;
  int cycles = 0;
  logic [31:0] rng = 32'h0000ACF6;
  logic [31:0] aq[$];
  logic [14:0] mq[$];
  logic [14:0] note;
  logic [7:0] ref_mem[logic [23:0]];
  logic [7:0] page_ref = 8'h00;
  logic gp_ref = 1'b0;
  logic mac_ref = 1'b0;
  logic req_d = 1'b0;
  logic [7:0] pg;
  logic [15:0] offs[5] = '{16'hDBFF, 16'hDC00, 16'hDFFF, 16'hE000, 16'hFFFF};

  ord_top u_ord_top (.MCLK(mclk), .RST(rst), .AV_ADDRESS(av_addr), .AV_READ(av_rd), .AV_WRITE(av_wr),
    .AV_WRITEDATA(av_wdata), .AV_BYTEENABLE(av_be), .AV_READDATA(av_rdata), .AV_WAITREQUEST(av_wait),
    .MEM_REQ(mem_req), .CS_RANGE(cs), .MEM_RDATA(mem_rdata), .MEM_RVALID(mem_rvalid),
    .MEM_GP_HIT(gp_hit), .MEM_MAC_HIT(mac_hit), .MEM_CS_N(cs_n));
  ord_cpu_model u_ord_cpu_model (.clk(mclk), .rst(rst), .cmd_valid(cmd_v), .cmd(cmd), .mem_req(mem_req));

  always #5 mclk = ~mclk;

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  task automatic chk(input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("[ERR] t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // Request held until waitrequest is sampled low; no latency assumed
  task automatic av(input logic w, input logic [9:0] a, input logic [7:0] d, input logic [3:0] be);
    @(posedge mclk);
    av_addr <= a;
    av_wdata <= {24'h000000, d};
    av_be <= be;
    av_rd <= ~w;
    av_wr <= w;
    do @(posedge mclk); while (av_wait !== 1'b0);
    av_rd <= 1'b0;
    av_wr <= 1'b0;
  endtask

  task automatic wreg(input logic [9:0] a, input logic [7:0] d, input logic [3:0] be);
    av(1'b1, a, d, be);
    if (be[0] && a == ord_pkg::PAGE_BADDR) page_ref = d;
    if (be[0] && a == ord_pkg::CTRL_BADDR) {gp_ref, mac_ref} = d[7:6];
  endtask

  task automatic rreg(input logic [9:0] a, input logic [31:0] e);
    aq.push_back(e);
    av(1'b0, a, 8'h00, 4'hF);
  endtask

  // Note the expected decode first, then issue the cycle
  task automatic mem(input logic r, input logic [23:0] a, input logic [7:0] d);
    logic gp, mac;
    logic [3:0] csn;
    gp = gp_ref && a[23:16] == page_ref && a[15:0] >= ord_pkg::GP_LO;
    mac = mac_ref && a[23:16] == page_ref && a[15:0] >= ord_pkg::MAC_LO && a[15:0] <= ord_pkg::MAC_HI;
    if (!r && (gp || mac)) ref_mem[a] = d;
    for (int i = 0; i < 4; i++)
      csn[i] = !(cs[i].enable && cs[i].lower <= a[23:16] && a[23:16] <= cs[i].upper && !gp && !mac);
    mq.push_back({r && (gp || mac), (r && (gp || mac)) ? ref_mem[a] : 8'h00, gp, mac, csn});
    @(posedge mclk);
    cmd <= '{addr: a, rd: r, wr: !r, wdata: d};
    cmd_v <= 1'b1;
  endtask

  // Scoreboard and hang guard; results are due one cycle after each access
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 20000) begin
      n_mismatch++;
      summarize();
    end else begin
      if (av_rd && av_wait === 1'b0) chk(aq.pop_front(), av_rdata);
      if (req_d === 1'b1) begin
        note = mq.pop_front();
        chk({17'h0, note}, {17'h0, mem_rvalid, note[14] ? mem_rdata : 8'h00, gp_hit, mac_hit, cs_n});
      end else if (!rst) chk(32'h0000000F, {27'h0, mem_rvalid, cs_n});
      req_d = mem_req.rd | mem_req.wr;
    end
  end

  initial begin
    repeat (5) @(posedge mclk);
    rst <= 1'b0;
    rreg(ord_pkg::PAGE_BADDR, 32'h00000000);
    rreg(ord_pkg::CTRL_BADDR, 32'h00000000);
    rreg(10'h004, 32'h00000000);
    wreg(ord_pkg::PAGE_BADDR, 8'h3C, 4'h0);
    wreg(10'h004, 8'h5A, 4'hF);
    wreg(ord_pkg::CTRL_BADDR, 8'hC0, 4'hE);
    rreg(ord_pkg::PAGE_BADDR, 32'h00000000);
    rreg(ord_pkg::CTRL_BADDR, 32'h00000000);
    $display("test regs done");
    for (int r = 0; r < 4; r++) begin
      rng = xs(rng);
      pg = rng[7:0];
      // Ranges: exact page, above it, disabled, and everything up to it
      cs[0] <= '{lower: pg, upper: pg, enable: 1'b1};
      cs[1] <= '{lower: pg + 8'h01, upper: 8'hFF, enable: 1'b1};
      cs[2] <= '{lower: 8'h00, upper: 8'hFF, enable: 1'b0};
      cs[3] <= '{lower: 8'h00, upper: pg, enable: 1'b1};
      wreg(ord_pkg::PAGE_BADDR, pg, 4'h1);
      wreg(ord_pkg::CTRL_BADDR, {r[1], r[0], 6'h3F}, 4'hF);
      rreg(ord_pkg::PAGE_BADDR, {24'h000000, pg});
      rreg(ord_pkg::CTRL_BADDR, {24'h000000, r[1], r[0], 6'h00});
      foreach (offs[k]) begin
        rng = xs(rng);
        mem(1'b0, {pg, offs[k]}, rng[7:0]);
        mem(1'b1, {pg ^ 8'h80, offs[k]}, 8'h00);
      end
      foreach (offs[k]) mem(1'b1, {pg, offs[k]}, 8'h00);
      @(posedge mclk);
      cmd_v <= 1'b0;
      repeat (3) @(posedge mclk);
      $display("test %0d done", r);
    end
    rst <= 1'b1;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    {gp_ref, mac_ref, page_ref} = 10'h000;
    rreg(ord_pkg::CTRL_BADDR, 32'h00000000);
    rreg(ord_pkg::PAGE_BADDR, 32'h00000000);
    repeat (3) @(posedge mclk);
    $display("test reset done");
    summarize();
  end
endmodule
